/* common/pcf_cfg.svh */
// pcf_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: wishbone byte addresses, 32-bit words, slow timebase near 32768 Hz
`ifndef PCF_CFG_SVH
`define PCF_CFG_SVH

// register byte addresses
`define PCF_ADR_MODE 8'h00
`define PCF_ADR_PULLUP 8'h04
`define PCF_ADR_DB_HIGH 8'h08
`define PCF_ADR_DB_LOW 8'h0C
`define PCF_ADR_EV_BASIC 8'h10
`define PCF_ADR_EV_ADV 8'h14
`define PCF_ADR_CNT0 8'h18
`define PCF_ADR_CNT1 8'h1C
`define PCF_ADR_CMP0 8'h20
`define PCF_ADR_CMP1 8'h24
`define PCF_ADR_IRQ_EN 8'h28
`define PCF_ADR_PWR_FLAGS 8'h2C

// field positions
`define PCF_MODE_STYLE 7:6
`define PCF_MODE_RATE 5:4
`define PCF_PU_CAL_GO 7
`define PCF_PU_CAL_FAIL 6
`define PCF_PU_CAL_SEL 5
`define PCF_PU_DRIVE 4:0
`define PCF_PU_RES 4:2
`define PCF_PU_DUTY 1:0
`define PCF_EV_EN_LSB 8
`define PCF_GIE_BIT 4
`define PCF_WAKE_EN_BIT 0
`define PCF_WOKE_CLR_BIT 1

// reset values
`define PCF_MODE_RST 8'h04
`define PCF_ZERO8 8'h00
`define PCF_ZERO24 24'h00_0000
`define PCF_ONES24 24'hFF_FFFF

// slow timebase in Hz and sample intervals in microseconds; PCF_TICKS converts them to slow ticks
`define PCF_SLOW_HZ 32768
`define PCF_T250_US 250
`define PCF_T500_US 500
`define PCF_T1000_US 1000
`define PCF_T2000_US 2000
`define PCF_TICKS(us) (((us) * `PCF_SLOW_HZ) / 1000000)
// charge window lengths for duty codes 00..11, same tick count at every rate
`define PCF_CHG_D0 7'd2
`define PCF_CHG_D1 7'd3
`define PCF_CHG_D2 7'd4
`define PCF_CHG_D3 7'd6
// resynchronisation after a block reset, in slow ticks
`define PCF_SYNC_TICKS 2'd2
// calibration: weakest enabled drive, strongest drive, samples per test
`define PCF_CAL_FIRST 5'h04
`define PCF_CAL_LAST 5'h1F
`define PCF_CAL_SAMPLES 2'd3
`define PCF_RES_OFF 3'h0

`endif

/* common/pcf_pkg.sv */
// pcf_pkg: types of the pulse counter front end
// assumes: included config header for all numeric values
package pcf_pkg;
  typedef enum logic [1:0] {PCF_DISABLED, PCF_SINGLE, PCF_DUAL, PCF_QUAD} pcf_style_type;
  typedef enum logic [1:0] {PCF_R250US, PCF_R500US, PCF_R1MS, PCF_R2MS} pcf_rate_type;
  typedef enum logic [1:0] {PCF_CAL_IDLE, PCF_CAL_RUN} pcf_cal_type;
endpackage

/* common/pcf_cnt_if.sv */
// pcf_cnt_if: request and result signals between the front end and one counter
// assumes: both ends on clk_i
`timescale 1ns/100ps
interface pcf_cnt_if;
  logic clear;
  logic inc;
  logic [23:0] cmp;
  logic [23:0] count;
  logic ovf;
  logic match;
  modport ctl (output clear, output inc, output cmp, input count, input ovf, input match);
  modport cnt (input clear, input inc, input cmp, output count, output ovf, output match);
endinterface

/* core/pcf_debounce.sv */
// pcf_debounce: dual threshold digital integrator for one pulse input
// assumes: sample_i is a one-cycle strobe, level_i already synchronised
`timescale 1ns/100ps
`include "pcf_cfg.svh"
module pcf_debounce (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic clear_i,
  input wire logic sample_i,
  input wire logic level_i,
  input wire logic [7:0] thr_high_i,
  input wire logic [7:0] thr_low_i,
  // result
  output logic out_o
);
  logic [7:0] integ;
  logic [7:0] low_mark;

  // falling edge is reached after thr_low steps down from the rising threshold
  assign low_mark = (thr_low_i >= thr_high_i) ? `PCF_ZERO8 : thr_high_i - thr_low_i;

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      integ <= `PCF_ZERO8;
      out_o <= 1'b0;
    end else if (sample_i) begin
      if (level_i) begin
        if (integ < thr_high_i) begin
          integ <= integ + 8'h01;
        end
        if (!out_o && (integ + 8'h01 >= thr_high_i)) begin
          out_o <= 1'b1;
        end
      end else begin
        if (integ != `PCF_ZERO8) begin
          integ <= integ - 8'h01;
        end
        if (out_o && (integ <= low_mark + 8'h01)) begin
          out_o <= 1'b0;
        end
      end
    end
  end

  a_db_rise_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(out_o) |-> $past(sample_i) && $past(level_i))
    else $error("debounce output rose without a high sample");
endmodule // pcf_debounce

/* core/pcf_counter.sv */
// pcf_counter: 24-bit up counter with wrap, overflow and comparator match pulses
// assumes: inc is a one-cycle pulse, clear has priority
`timescale 1ns/100ps
`include "pcf_cfg.svh"
module pcf_counter (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // counter port
  pcf_cnt_if.cnt cif
);
  always_ff @(posedge clk_i) begin
    if (cif.clear) begin
      cif.count <= `PCF_ZERO24;
    end else if (cif.inc) begin
      cif.count <= cif.count + 24'h00_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || cif.clear) begin
      cif.ovf <= 1'b0;
      cif.match <= 1'b0;
    end else begin
      cif.ovf <= cif.inc && (cif.count == `PCF_ONES24);
      cif.match <= cif.inc && (cif.count + 24'h00_0001 == cif.cmp);
    end
  end

  a_cnt_wrap_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    cif.ovf |-> cif.count == `PCF_ZERO24 && $past(cif.count) == `PCF_ONES24)
    else $error("overflow without wrap to zero");
  c_cnt_overflow: cover property (@(posedge clk_i) disable iff (rst_i) cif.ovf);
endmodule // pcf_counter

/* core/pcf_frontend.sv */
// pcf_frontend: pulse counter front end, pull-up duty control, calibration,
// debounce, counters and event flags behind a classic wishbone slave
// assumes: slow_clk_i and pulse_input_*_i are asynchronous pins
// Functional notes
// - calibration tests only the input chosen by the select bit
// - during calibration integrators ignore samples and counters hold
// - at most 28 tests of three samples each, stopping early on success
// - report failure if the chosen input never samples high
// - calibration writes drive field; one strength drives both pull-ups
// - sample interval from slow timebase, 250 us to 2 ms
// - 500 us rate duties 12.5 to 37.5 percent; resistor code 000 off
// - 1 ms rate duties 6.3 to 18.8 percent
// - 2 ms rate duties 3.1 to 9.4 percent; the 65-tick interval gives 3.1 to 9.2
// - pull-up on only in charge window; sample when charging ends
// - output rises after high threshold of cumulative high samples
// - separate low threshold sets the falling point
// - integrator goes up on high, down on low, not consecutive
// - processor reset clears neither counters nor configuration
// - master mode write clears counters and every other block register
// - counting halts after processor reset until slow clock runs
// - no counting for two slow ticks after a block reset
// - interrupt needs source enable and global enable bit 4
// - wake needs source enable and wake enable bit 0; reads set after wake
// - event flags stay set until firmware clears them
// - basic events: comparator match, overflow, direction change
// - advanced events: flutter, quadrature error, calibrated input opens; the flutter flag (bit 0) is tied to zero and never set
// - rate codes 00..11 are 250 us, 500 us, 1 ms, 2 ms
// - style codes: disabled, single, dual, quadrature
// - 24-bit counters only increment and wrap to zero as overflow
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/100ps
`include "pcf_cfg.svh"
module pcf_frontend (
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bat_rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pins
  input wire logic slow_clk_i,
  input wire logic pulse_input_a_i,
  input wire logic pulse_input_b_i,
  output logic [1:0] pullup_en_o,
  output logic [2:0] pullup_strength_o,
  // system
  input wire logic sleep_i,
  output logic irq_o,
  output logic wake_o,
  output pcf_pkg::pcf_style_type style_o
);
  import pcf_pkg::*;

  logic [7:0] master_mode_reg;
  logic [7:0] pullup_config_reg;
  logic [7:0] debounce_high_threshold;
  logic [7:0] debounce_low_threshold;
  logic [4:0] ev_basic_flag, ev_basic_en;
  logic [2:0] ev_adv_flag, ev_adv_en;
  logic [23:0] cmp_val [2];
  logic [7:0] ext_irq_enable_2;
  logic counter_wake_enable, woke;
  logic [1:0] slow_sync, a_sync, b_sync;
  logic slow_prev, tick;
  logic [6:0] phase, next_phase, interval, charge;
  logic sample;
  logic [1:0] pin_level, sampled, db_out, db_prev;
  logic clk_ok;
  logic [1:0] sync_cnt;
  pcf_cal_type cal_state;
  logic [1:0] cal_samples;
  logic cal_busy, count_ok;
  logic wr, rd_req, block_clear, wr_mode;
  logic [1:0] inc, quad_step;
  logic quad_cw, quad_ccw, quad_err, last_dir, dir_valid;
  logic [4:0] basic_set, basic_clr;
  logic [2:0] adv_set, adv_clr;

  // bus: answer one cycle after the request, writes commit on the ack edge
  assign wr = cyc_i && stb_i && we_i && ack_o;
  assign rd_req = cyc_i && stb_i && !ack_o;
  assign wr_mode = wr && sel_i[0] && (adr_i == `PCF_ADR_MODE);
  assign block_clear = bat_rst_i || wr_mode;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  pcf_cnt_if cnt_bus [2] ();

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_req) begin
      case (adr_i)
        `PCF_ADR_MODE: dat_o <= {24'h00_0000, master_mode_reg};
        `PCF_ADR_PULLUP: dat_o <= {24'h00_0000, pullup_config_reg};
        `PCF_ADR_DB_HIGH: dat_o <= {24'h00_0000, debounce_high_threshold};
        `PCF_ADR_DB_LOW: dat_o <= {24'h00_0000, debounce_low_threshold};
        `PCF_ADR_EV_BASIC: dat_o <= {19'h0_0000, ev_basic_en, 3'h0, ev_basic_flag};
        `PCF_ADR_EV_ADV: dat_o <= {21'h00_0000, ev_adv_en, 5'h00, ev_adv_flag};
        `PCF_ADR_CNT0: dat_o <= {8'h00, cnt_bus[0].count};
        `PCF_ADR_CNT1: dat_o <= {8'h00, cnt_bus[1].count};
        `PCF_ADR_CMP0: dat_o <= {8'h00, cmp_val[0]};
        `PCF_ADR_CMP1: dat_o <= {8'h00, cmp_val[1]};
        `PCF_ADR_IRQ_EN: dat_o <= {24'h00_0000, ext_irq_enable_2};
        `PCF_ADR_PWR_FLAGS: dat_o <= {30'h0000_0000, counter_wake_enable, woke};
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // block registers: only the battery domain reset or a mode write clears them
  always_ff @(posedge clk_i) begin
    if (bat_rst_i) begin
      master_mode_reg <= `PCF_MODE_RST;
    end else if (wr_mode) begin
      master_mode_reg <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (block_clear) begin
      debounce_high_threshold <= `PCF_ZERO8;
      debounce_low_threshold <= `PCF_ZERO8;
      cmp_val[0] <= `PCF_ZERO24;
      cmp_val[1] <= `PCF_ZERO24;
    end else if (wr) begin
      if (sel_i[0] && adr_i == `PCF_ADR_DB_HIGH) debounce_high_threshold <= dat_i[7:0];
      if (sel_i[0] && adr_i == `PCF_ADR_DB_LOW) debounce_low_threshold <= dat_i[7:0];
      for (int i = 0; i < 3; i++) begin
        if (sel_i[i] && adr_i == `PCF_ADR_CMP0) cmp_val[0][i*8 +: 8] <= dat_i[i*8 +: 8];
        if (sel_i[i] && adr_i == `PCF_ADR_CMP1) cmp_val[1][i*8 +: 8] <= dat_i[i*8 +: 8];
      end
    end
  end

  // processor-side enables follow the processor reset, not the block
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_irq_enable_2 <= `PCF_ZERO8;
      counter_wake_enable <= 1'b0;
    end else if (wr && sel_i[0]) begin
      if (adr_i == `PCF_ADR_IRQ_EN) ext_irq_enable_2 <= dat_i[7:0];
      if (adr_i == `PCF_ADR_PWR_FLAGS) counter_wake_enable <= dat_i[`PCF_WAKE_EN_BIT];
    end
  end

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_sync <= 2'b00;
      a_sync <= 2'b00;
      b_sync <= 2'b00;
      slow_prev <= 1'b0;
    end else begin
      slow_sync <= {slow_sync[0], slow_clk_i};
      a_sync <= {a_sync[0], pulse_input_a_i};
      b_sync <= {b_sync[0], pulse_input_b_i};
      slow_prev <= slow_sync[1];
    end
  end
  assign tick = slow_sync[1] && !slow_prev;
  assign pin_level = {b_sync[1], a_sync[1]};

  // sample interval and charge window in slow ticks
  always_comb begin
    case (pcf_rate_type'(master_mode_reg[`PCF_MODE_RATE]))
      PCF_R250US: interval = 7'(`PCF_TICKS(`PCF_T250_US));
      PCF_R500US: interval = 7'(`PCF_TICKS(`PCF_T500_US));
      PCF_R1MS: interval = 7'(`PCF_TICKS(`PCF_T1000_US));
      PCF_R2MS: interval = 7'(`PCF_TICKS(`PCF_T2000_US));
      default: interval = 7'(`PCF_TICKS(`PCF_T250_US));
    endcase
    case (pullup_config_reg[`PCF_PU_DUTY])
      2'b00: charge = `PCF_CHG_D0;
      2'b01: charge = `PCF_CHG_D1;
      2'b10: charge = `PCF_CHG_D2;
      default: charge = `PCF_CHG_D3;
    endcase
    next_phase = (phase + 7'd1 >= interval) ? 7'd0 : phase + 7'd1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || block_clear) begin
      phase <= 7'd0;
    end else if (tick) begin
      phase <= next_phase;
    end
  end
  assign sample = tick && (next_phase == 7'd0);

  // pull-up on only in the charge window ending at the sample point
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pullup_en_o <= 2'b00;
      pullup_strength_o <= `PCF_RES_OFF;
    end else begin
      pullup_strength_o <= pullup_config_reg[`PCF_PU_RES];
      if (pullup_config_reg[`PCF_PU_RES] != `PCF_RES_OFF && clk_ok
          && phase >= interval - charge) begin
        pullup_en_o <= 2'b11;
      end else begin
        pullup_en_o <= 2'b00;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sampled <= 2'b00;
    end else if (sample) begin
      sampled <= pin_level;
    end
  end

  // clock-running gate and post-reset resync
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_ok <= 1'b0;
    end else if (tick) begin
      clk_ok <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (block_clear) begin
      sync_cnt <= `PCF_SYNC_TICKS;
    end else if (tick && sync_cnt != 2'd0) begin
      sync_cnt <= sync_cnt - 2'd1;
    end
  end

  // calibration: weakest drive upward, three samples per step
  assign cal_busy = (cal_state == PCF_CAL_RUN);
  always_ff @(posedge clk_i) begin
    if (block_clear) begin
      cal_state <= PCF_CAL_IDLE;
      cal_samples <= 2'd0;
      pullup_config_reg <= `PCF_ZERO8;
    end else if (wr && sel_i[0] && adr_i == `PCF_ADR_PULLUP && !cal_busy) begin
      pullup_config_reg <= {1'b0, 1'b0, dat_i[5:0]};
      if (dat_i[`PCF_PU_CAL_GO]) begin
        cal_state <= PCF_CAL_RUN;
        cal_samples <= 2'd0;
        pullup_config_reg[`PCF_PU_DRIVE] <= `PCF_CAL_FIRST;
        pullup_config_reg[`PCF_PU_CAL_GO] <= 1'b1;
      end
    end else begin
      case (cal_state)
        PCF_CAL_IDLE: cal_state <= PCF_CAL_IDLE;
        PCF_CAL_RUN: begin
          if (sample) begin
            if (pin_level[pullup_config_reg[`PCF_PU_CAL_SEL]]) begin
              cal_state <= PCF_CAL_IDLE;
              pullup_config_reg[`PCF_PU_CAL_GO] <= 1'b0;
            end else if (cal_samples == `PCF_CAL_SAMPLES - 2'd1) begin
              cal_samples <= 2'd0;
              if (pullup_config_reg[`PCF_PU_DRIVE] == `PCF_CAL_LAST) begin
                cal_state <= PCF_CAL_IDLE;
                pullup_config_reg[`PCF_PU_CAL_GO] <= 1'b0;
                pullup_config_reg[`PCF_PU_CAL_FAIL] <= 1'b1;
              end else begin
                pullup_config_reg[`PCF_PU_DRIVE] <= pullup_config_reg[`PCF_PU_DRIVE] + 5'h01;
              end
            end else begin
              cal_samples <= cal_samples + 2'd1;
            end
          end
        end
        default: cal_state <= PCF_CAL_IDLE;
      endcase
    end
  end

  // debounce and counters per input; config already lives in this domain
  assign count_ok = clk_ok && sync_cnt == 2'd0 && !cal_busy;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      pcf_debounce u_db (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(block_clear),
        .sample_i(sample && !cal_busy),
        .level_i(pin_level[g]),
        .thr_high_i(debounce_high_threshold),
        .thr_low_i(debounce_low_threshold),
        .out_o(db_out[g])
      );
      assign cnt_bus[g].clear = block_clear;
      assign cnt_bus[g].inc = inc[g];
      assign cnt_bus[g].cmp = cmp_val[g];
      pcf_counter u_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cif(cnt_bus[g])
      );
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (block_clear) begin
      db_prev <= 2'b00;
      last_dir <= 1'b0;
      dir_valid <= 1'b0;
    end else if (db_out != db_prev && count_ok) begin
      db_prev <= db_out;
      if (quad_cw || quad_ccw) begin
        last_dir <= quad_ccw;
        dir_valid <= 1'b1;
      end
    end
  end

  // quadrature: gray order 00,01,11,10 forward, {b,a}
  assign quad_step = {db_prev[0], !db_prev[1]};
  assign quad_cw = db_out == quad_step;
  assign quad_ccw = db_out == {!db_prev[0], db_prev[1]};
  assign quad_err = (db_out != db_prev) && !quad_cw && !quad_ccw;
  assign style_o = pcf_style_type'(master_mode_reg[`PCF_MODE_STYLE]);

  always_comb begin
    inc = 2'b00;
    if (count_ok) begin
      case (style_o)
        PCF_DISABLED: inc = 2'b00;
        PCF_SINGLE: inc = {1'b0, db_out[0] && !db_prev[0]};
        PCF_DUAL: inc = db_out & ~db_prev;
        PCF_QUAD: inc = {quad_ccw, quad_cw};
        default: inc = 2'b00;
      endcase
    end
  end

  // events: set wins over the write-one clear
  assign basic_set = {count_ok && style_o == PCF_QUAD && dir_valid && (quad_cw || quad_ccw)
                      && (quad_ccw != last_dir),
                      cnt_bus[1].ovf, cnt_bus[0].ovf, cnt_bus[1].match, cnt_bus[0].match};
  assign adv_set = {cal_busy && sample && pin_level[pullup_config_reg[`PCF_PU_CAL_SEL]]
                    && !sampled[pullup_config_reg[`PCF_PU_CAL_SEL]],
                    count_ok && style_o == PCF_QUAD && quad_err, 1'b0};
  assign basic_clr = (wr && sel_i[0] && adr_i == `PCF_ADR_EV_BASIC) ? dat_i[4:0] : 5'h00;
  assign adv_clr = (wr && sel_i[0] && adr_i == `PCF_ADR_EV_ADV) ? dat_i[2:0] : 3'h0;

  always_ff @(posedge clk_i) begin
    if (block_clear) begin
      ev_basic_flag <= 5'h00;
      ev_adv_flag <= 3'h0;
      ev_basic_en <= 5'h00;
      ev_adv_en <= 3'h0;
    end else begin
      ev_basic_flag <= (ev_basic_flag & ~basic_clr) | basic_set;
      ev_adv_flag <= (ev_adv_flag & ~adv_clr) | adv_set;
      if (wr && sel_i[1] && adr_i == `PCF_ADR_EV_BASIC) ev_basic_en <= dat_i[12:8];
      if (wr && sel_i[1] && adr_i == `PCF_ADR_EV_ADV) ev_adv_en <= dat_i[10:8];
    end
  end

  logic any_src;
  assign any_src = |(ev_basic_flag & ev_basic_en) || |(ev_adv_flag & ev_adv_en);
  assign irq_o = any_src && ext_irq_enable_2[`PCF_GIE_BIT];
  assign wake_o = any_src && counter_wake_enable;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      woke <= 1'b0;
    end else if (sleep_i && wake_o) begin
      woke <= 1'b1;
    end else if (wr && sel_i[0] && adr_i == `PCF_ADR_PWR_FLAGS && dat_i[`PCF_WOKE_CLR_BIT]) begin
      woke <= 1'b0;
    end
  end

  // checks
  a_cal_holds_count: assert property (@(posedge clk_i) disable iff (rst_i)
    cal_busy |-> inc == 2'b00)
    else $error("counter advanced during calibration");
  a_cal_first_drive: assert property (@(posedge clk_i) disable iff (rst_i || bat_rst_i)
    $rose(cal_busy) |-> pullup_config_reg[`PCF_PU_DRIVE] == `PCF_CAL_FIRST)
    else $error("calibration did not start at weakest drive");
  a_res_off_pullup: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(pullup_config_reg[`PCF_PU_RES]) == `PCF_RES_OFF |-> pullup_en_o == 2'b00)
    else $error("pull-up on with resistor code off");
  a_pullup_window: assert property (@(posedge clk_i) disable iff (rst_i)
    pullup_en_o != 2'b00 |-> $past(phase) >= $past(interval) - $past(charge))
    else $error("pull-up on outside charge window");
  a_mode_clears_all: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mode |=> cnt_bus[0].count == `PCF_ZERO24 && cnt_bus[1].count == `PCF_ZERO24
                && ev_basic_flag == 5'h00 && !cal_busy)
    else $error("mode write did not clear block state");
  a_sync_no_count: assert property (@(posedge clk_i) disable iff (rst_i)
    sync_cnt != 2'd0 || !clk_ok |-> inc == 2'b00)
    else $error("count during resynchronisation");
  a_irq_needs_gie: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> ext_irq_enable_2[`PCF_GIE_BIT] && any_src)
    else $error("interrupt without global enable");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i || block_clear)
    ev_basic_flag[0] && !basic_clr[0] |=> ev_basic_flag[0])
    else $error("event flag dropped without clear");
  a_cal_fail_end: assert property (@(posedge clk_i) disable iff (rst_i || block_clear)
    $rose(pullup_config_reg[`PCF_PU_CAL_FAIL]) |-> !cal_busy
      && pullup_config_reg[`PCF_PU_DRIVE] == `PCF_CAL_LAST)
    else $error("calibration failure before last drive");
  c_cal_pass: cover property (@(posedge clk_i)
    $fell(cal_busy) && !pullup_config_reg[`PCF_PU_CAL_FAIL]);
  c_cal_fail: cover property (@(posedge clk_i) $rose(pullup_config_reg[`PCF_PU_CAL_FAIL]));
  c_irq_raised: cover property (@(posedge clk_i) $rose(irq_o));
  c_wake_raised: cover property (@(posedge clk_i) sleep_i && wake_o);
endmodule // pcf_frontend

/* sim/pcf_reed_model.sv */
// pcf_reed_model: two reed switches, line charged by the pull-up, slow decay
// assumes: open_i from the bench, pu_i from the block's pull-up enables
`timescale 1ns/100ps
module pcf_reed_model (
  // clock
  input wire logic clk_i,
  // switches and pull-ups
  input wire logic [1:0] open_i,
  input wire logic [1:0] pu_i,
  // lines to the block
  output logic [1:0] pin_o
);
  logic [5:0] hold [2] = '{6'h00, 6'h00};
  // a closed switch grounds the line; an open one keeps charge a short while
  always @(posedge clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (!open_i[k]) hold[k] <= 6'h00;
      else if (pu_i[k]) hold[k] <= 6'h28;
      else if (hold[k] != 6'h00) hold[k] <= hold[k] - 6'h01;
      pin_o[k] <= (hold[k] != 6'h00);
    end
  end
endmodule // pcf_reed_model

/* sim/pulse_counter_frontend_test.sv */
// pulse_counter_frontend_test: duty, calibration, debounce counts, events
// assumes: slow timebase run fast, 20 clocks per tick
`timescale 1ns/100ps
`include "pcf_cfg.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module pulse_counter_frontend_test;
  import pcf_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, bat_rst_i = 1'h1, slow = 1'h0, sleep = 1'h0;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, ack_o, irq_o, wake_o;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rd, dat_o, c0, seed = 32'h0000_004F;
  logic [1:0] pu_en, pins, open = 2'h3;
  logic [2:0] strength;
  pcf_style_type style;
  int fails = 0, total_checks = 0, n;
  localparam int PM [4][4] = '{'{250, 375, 500, 750}, '{125, 188, 250, 375},
    '{63, 94, 125, 188}, '{31, 47, 63, 94}};
  pcf_frontend pcf_frontend_i (.clk_i(clk_i), .rst_i(rst_i), .bat_rst_i(bat_rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat),
    .dat_o(dat_o), .ack_o(ack_o), .slow_clk_i(slow), .pulse_input_a_i(pins[0]),
    .pulse_input_b_i(pins[1]), .pullup_en_o(pu_en), .pullup_strength_o(strength),
    .sleep_i(sleep), .irq_o(irq_o), .wake_o(wake_o), .style_o(style));
  pcf_reed_model pcf_reed_model_i (.clk_i(clk_i), .open_i(open), .pu_i(pu_en), .pin_o(pins));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always #100 slow = ~slow;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin @(posedge clk_i); end while (ack_o !== 1'h1);
    rd = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    // the write lands on the ack edge; outputs are looked at one edge later
    @(posedge clk_i);
  endtask
  // expected pull-up cycles over two sample intervals
  task automatic duty_chk(input int r, input int res, input int d);
    int on, sk, t, e;
    on = 0;
    sk = 0;
    t = ((250 << r) * 32768 / 1000000) * 40;
    e = (res == 0) ? 0 : t * PM[r][d] / 1000;
    wb(1'h1, `PCF_ADR_MODE, 32'(r << 4));
    wb(1'h1, `PCF_ADR_PULLUP, 32'(res * 4 + d));
    repeat (t + 40) @(posedge clk_i);
    repeat (t) begin @(posedge clk_i); on += pu_en[0]; sk += (pu_en[1] !== pu_en[0]); end
    `CHK("duty", 1'h1, (on - e) inside {[-24:24]})
    `CHK("both pullups", 0, sk)
    `CHK("strength", 3'(res), strength)
  endtask
  task automatic wait_cal();
    rd = 32'h0000_0080;
    for (int k = 0; k < 1000 && rd[7]; k++) begin repeat (20) @(posedge clk_i);
      wb(1'h0, `PCF_ADR_PULLUP, 32'h0000_0000); end
  endtask
  task automatic pulse(input int m);
    repeat (m) begin open[0] <= 1'h1; repeat (960) @(posedge clk_i);
      open[0] <= 1'h0; repeat (960) @(posedge clk_i); end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #900_000 fails++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    bat_rst_i <= 1'h0;
    wb(1'h0, `PCF_ADR_MODE, 32'h0000_0000);
    `CHK("mode reset", 32'h0000_0004, rd)
    wb(1'h0, 8'h3C, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rd)
    for (int r = 0; r < 4; r++) for (int d = 0; d < 4; d++) duty_chk(r, 1 + d, d);
    duty_chk(1, 0, 3);
    $display("duty test done");
    wb(1'h1, `PCF_ADR_MODE, 32'h0000_0040);
    wb(1'h1, `PCF_ADR_PULLUP, 32'h0000_0080);
    wait_cal();
    `CHK("cal a pass", 32'h0000_0004, rd & 32'h0000_00DF)
    open <= 2'h1;
    wb(1'h0, `PCF_ADR_CNT0, 32'h0000_0000);
    c0 = rd;
    wb(1'h1, `PCF_ADR_PULLUP, 32'h0000_00A0);
    fork pulse(2); wait_cal(); join
    `CHK("cal b fail", 1'h1, rd[6])
    wb(1'h0, `PCF_ADR_CNT0, 32'h0000_0000);
    `CHK("cal hold", c0, rd)
    $display("calibration test done");
    open <= 2'h0;
    n = 32'(rnd() % 4 + 2);
    wb(1'h1, `PCF_ADR_MODE, 32'h0000_0040);
    `CHK("style", PCF_SINGLE, style)
    wb(1'h1, `PCF_ADR_PULLUP, 32'h0000_0004);
    wb(1'h1, `PCF_ADR_DB_HIGH, 32'(rnd() % 2 + 1));
    wb(1'h1, `PCF_ADR_DB_LOW, 32'(rnd() % 2 + 1));
    wb(1'h1, `PCF_ADR_CMP0, 32'(n));
    wb(1'h1, `PCF_ADR_EV_BASIC, 32'h0000_0100);
    pulse(n);
    `CHK("no global enable", 1'h0, irq_o)
    wb(1'h1, `PCF_ADR_IRQ_EN, 32'h0000_0010);
    `CHK("irq", 1'h1, irq_o)
    wb(1'h0, `PCF_ADR_CNT0, 32'h0000_0000);
    `CHK("count", 32'(n), rd)
    sleep <= 1'h1;
    wb(1'h1, `PCF_ADR_PWR_FLAGS, 32'h0000_0001);
    `CHK("wake", 1'h1, wake_o)
    wb(1'h0, `PCF_ADR_PWR_FLAGS, 32'h0000_0000);
    `CHK("woke flag", 32'h0000_0003, rd)
    wb(1'h1, `PCF_ADR_EV_BASIC, 32'h0000_0101);
    `CHK("flag cleared", 1'h0, irq_o)
    $display("event test done");
    rst_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, `PCF_ADR_CNT0, 32'h0000_0000);
    `CHK("count kept", 32'(n), rd)
    wb(1'h1, `PCF_ADR_MODE, 32'h0000_0040);
    wb(1'h0, `PCF_ADR_CNT0, 32'h0000_0000);
    `CHK("count cleared", 32'h0000_0000, rd)
    wb(1'h0, `PCF_ADR_DB_HIGH, 32'h0000_0000);
    `CHK("threshold cleared", 32'h0000_0000, rd)
    $display("reset test done");
    complete_run();
  end
endmodule // pulse_counter_frontend_test
